// ==== bench/stmf_far_end.sv ====
`timescale 1ns/10ps
`default_nettype none
module stmf_far_end (
	input  wire logic        clk_i,
	input  wire logic        far_nt_i,
	input  wire logic [3:0]  q_i,
	input  wire logic [19:0] sc_i,
	input  wire logic        cv_i,
	input  wire logic        tx_m_i,
	output logic             frame_tick_o,
	output logic             rx_tick_o,
	output logic [5:0]       rx_pos_o,
	output logic             rx_bit_o,
	output logic             rx_cv_o
);
	int fi = 19;
	initial begin
		frame_tick_o = 1'b0;
		rx_tick_o    = 1'b0;
		rx_pos_o     = 6'h00;
		rx_bit_o     = 1'b0;
		rx_cv_o      = 1'b0;
	end
	// the bit line is inverted after each tick so a stale value is never read as good
	task automatic send(input logic [5:0] p, input logic v);
		@(posedge clk_i);
		rx_tick_o <= 1'b1;
		rx_pos_o  <= p;
		rx_bit_o  <= v;
		@(posedge clk_i);
		rx_tick_o <= 1'b0;
		rx_bit_o  <= ~v;
	endtask
	task automatic frame();
		logic qf;
		@(posedge clk_i);
		frame_tick_o <= 1'b1;
		@(posedge clk_i);
		frame_tick_o <= 1'b0;
		repeat (2) @(posedge clk_i);
		// a far TE follows the M bit it hears, a far NT counts on its own
		fi = (!far_nt_i && tx_m_i) || fi == 19 ? 0 : fi + 1;
		qf = fi % 5 == 0;
		send(6'h0e, far_nt_i ? qf : qf && q_i[3 - fi / 5]);
		send(6'h1a, far_nt_i && fi == 0);
		send(6'h25, far_nt_i && sc_i[19 - 4 * (fi % 5) - fi / 5]);
		if (cv_i) begin
			@(posedge clk_i);
			rx_cv_o <= 1'b1;
			@(posedge clk_i);
			rx_cv_o <= 1'b0;
		end
	endtask
endmodule
`default_nettype wire

// ==== bench/testbench.sv ====
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import stmf_pkg::*;
	localparam int TMO = 20000;
	logic              clk_i  = 1'b0;
	logic              nrst_i = 1'b0;
	logic              nt     = 1'b1;
	logic [ADDR_W-1:0] addr   = '0;
	logic              rd_s   = 1'b0;
	logic              wr_s   = 1'b0;
	logic [31:0]       wdat   = 32'h0000_0000;
	logic [31:0]       rdat;
	logic              wait_o, fa, m, s, irq, ft, rt, rb, rcv;
	logic [5:0]        rp;
	logic [3:0]        q      = 4'hf; // unaddressed TE keeps Q all ones
	logic [19:0]       sc     = 20'h0_0000;
	logic [19:0]       img, sh;
	logic              cv     = 1'b0;
	logic              ce     = 1'b1;
	logic              run    = 1'b0;
	logic [2:0]        td     = 3'b000;
	logic [7:0]        rq[$];
	logic [2:0]        txq[$];
	logic [31:0]       rng    = 32'h906d_2007;
	int                n_fail = 0, n_compared = 0, cyc = 0, fi = 0;

	initial begin
		forever #10 clk_i = ~clk_i;
	end

	stmf_channel DUT (
		.clk_i(clk_i), .nrst_i(nrst_i), .ce_i(ce), .nt_mode_i(nt),
		.frame_tick_i(ft), .rx_tick_i(rt), .rx_pos_i(rp), .rx_bit_i(rb), .rx_cv_i(rcv),
		.avs_address_i(addr), .avs_read_i(rd_s), .avs_write_i(wr_s),
		.avs_writedata_i(wdat), .avs_byteenable_i(4'hf), .avs_readdata_o(rdat),
		.avs_waitrequest_o(wait_o), .tx_fa_o(fa), .tx_m_o(m), .tx_s_o(s), .irq_o(irq)
	);
	stmf_far_end u_far (
		.clk_i(clk_i), .far_nt_i(!nt), .q_i(q), .sc_i(sc), .cv_i(cv), .tx_m_i(m),
		.frame_tick_o(ft), .rx_tick_o(rt), .rx_pos_o(rp), .rx_bit_o(rb), .rx_cv_o(rcv)
	);

	function automatic logic [19:0] xs20();
		rng = rng ^ (rng << 13);
		rng = rng ^ (rng >> 17);
		rng = rng ^ (rng << 5);
		return rng[19:0];
	endfunction

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic final_report();
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic do_reset(input logic mode);
		@(posedge clk_i);
		nrst_i <= 1'b0;
		nt     <= mode;
		repeat (2) @(posedge clk_i);
		nrst_i <= 1'b1;
	endtask

	// request held until waitrequest is seen low; only the timeout ends a hang
	task automatic acc(input logic w, input logic [ADDR_W-1:0] a, input logic [7:0] d);
		@(posedge clk_i);
		rd_s <= !w;
		wr_s <= w;
		addr <= a;
		wdat <= {24'h00_0000, d};
		do @(posedge clk_i); while (wait_o !== 1'b0);
		rd_s <= 1'b0;
		wr_s <= 1'b0;
	endtask

	task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] e);
		rq.push_back(e);
		acc(1'b0, a, 8'h00);
	endtask

	task automatic wimg();
		img = xs20();
		acc(1'b1, OFS_S_TX_SC1, {img[19:16], 4'h0});
		acc(1'b1, OFS_S_SC23, img[15:8]);
		acc(1'b1, OFS_S_SC45, img[7:0]);
	endtask

	task automatic step(input logic c);
		logic tq;
		if (nt && run) begin
			if (fi == 0) begin
				sh = img;
			end
			txq.push_back({fi % 5 == 0, fi == 0, sh[19 - 4 * (fi % 5) - fi / 5]});
			fi = fi == 19 ? 0 : fi + 1;
		end else if (nt) begin
			txq.push_back(3'b000);
		end else begin
			// te: first frame echoes Fa, then Q bits go out in frames 1, 6, 11, 16
			if (u_far.fi == 19) begin
				sh[19:16] = q;
			end
			tq = run && u_far.fi % 5 == 4 && sh[19 - (u_far.fi + 1) % 20 / 5];
			txq.push_back({tq, 2'b00});
			run = 1'b1;
		end
		cv = c;
		u_far.frame();
	endtask

	task automatic mf(input int n, input int at);
		for (int i = 0; i < n; i++) begin
			step(i == at);
		end
	endtask

	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		td  <= {td[1:0], ft};
		if (rd_s && wait_o === 1'b0) begin
			check(rdat, {24'h00_0000, rq.pop_front()});
		end
		if (td[2] && txq.size() > 0) begin
			check({29'h0, fa, m, s}, {29'h0, txq.pop_front()});
		end
		if (cyc == TMO) begin
			n_fail++;
			final_report();
		end
	end

	initial begin
		do_reset(1'b1);
		for (int i = 0; i < 8; i++) begin
			rd(5'(4 * i), i == 3 ? 8'hf0 : 8'h00);
		end
		wimg();
		mf(3, 99);
		acc(1'b1, OFS_IRQ_EN, 8'h06);
		acc(1'b1, OFS_CTRL, 8'h20);
		run = 1'b1;
		fi  = 0;
		q   = 4'ha;
		mf(10, 99);
		// fresh values mid-multiframe must wait for the boundary
		wimg();
		mf(11, 99);
		rd(OFS_MF_STAT, 8'ha0);
		rd(OFS_IRQ_STAT, 8'h04);
		check({31'h0, irq}, 32'h0000_0001);
		rd(OFS_CTRL, 8'h22);
		acc(1'b1, OFS_IRQ_STAT, 8'h00);
		acc(1'b1, OFS_MF_STAT, 8'h50);
		rd(OFS_MF_STAT, 8'ha0);
		mf(20, 7);
		rd(OFS_IRQ_STAT, 8'h02);
		check({31'h0, irq}, 32'h0000_0001);
		acc(1'b1, OFS_IRQ_STAT, 8'h00);
		acc(1'b1, OFS_IRQ_EN, 8'h04);
		acc(1'b1, OFS_MF_STAT, 8'h04);
		// Q bit of frame 1 rides on the last step of a call, so change Q a multiframe early
		q = 4'h3;
		mf(20, 3);
		rd(OFS_IRQ_STAT, 8'h06);
		acc(1'b1, OFS_IRQ_STAT, 8'h02);
		rd(OFS_IRQ_STAT, 8'h02);
		check({31'h0, irq}, 32'h0000_0000);
		acc(1'b1, OFS_IRQ_EN, 8'h00);
		mf(20, 99);
		rd(OFS_MF_STAT, 8'h34);
		check({31'h0, irq}, 32'h0000_0000);
		acc(1'b1, OFS_CTRL, 8'h00);
		run = 1'b0;
		mf(2, 99);
		do_reset(1'b0);
		q = 4'hf;
		rd(OFS_S_TX_SC1, 8'hf0);
		rd(OFS_MF_STAT, 8'h00);
		acc(1'b1, OFS_IRQ_EN, 8'h04);
		// SC1 kept non-zero so the first commit differs from the reset value
		sc = xs20() | 20'h8_0000;
		u_far.fi = 19;
		mf(21, 99);
		rd(OFS_CTRL, 8'h02);
		rd(OFS_MF_STAT, {sc[19:16], 4'h0});
		rd(OFS_S_SC23, sc[15:8]);
		rd(OFS_S_SC45, sc[7:0]);
		rd(OFS_IRQ_STAT, 8'h04);
		check({31'h0, irq}, 32'h0000_0001);
		acc(1'b1, OFS_IRQ_STAT, 8'h00);
		acc(1'b1, OFS_S_SC23, ~sc[15:8]);
		// a new Q nibble goes out only from the next boundary on
		q = 4'h5;
		acc(1'b1, OFS_S_TX_SC1, {q, 4'h0});
		img = xs20();
		sc[15:0] = img[15:0];
		mf(20, 99);
		rd(OFS_IRQ_STAT, 8'h00);
		rd(OFS_S_SC23, sc[15:8]);
		rd(OFS_S_TX_SC1, {q, 4'h0});
		// clock enable low must hold the bus handshake where it is
		ce <= 1'b0;
		fork
			acc(1'b1, OFS_IRQ_EN, 8'h02);
			begin
				repeat (4) @(posedge clk_i);
				check({31'h0, wait_o}, 32'h0000_0001);
				ce <= 1'b1;
			end
		join
		rd(OFS_IRQ_EN, 8'h02);
		final_report();
	end
endmodule
`default_nettype wire

// ==== verilog/stmf_channel.sv ====
// Register access over Avalon-MM and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module stmf_channel
	import stmf_pkg::*;
(
	input  wire logic              clk_i,
	input  wire logic              nrst_i,
	input  wire logic              ce_i,
	input  wire logic              nt_mode_i,
	input  wire logic              frame_tick_i,
	input  wire logic              rx_tick_i,
	input  wire logic [5:0]        rx_pos_i,
	input  wire logic              rx_bit_i,
	input  wire logic              rx_cv_i,
	input  wire logic [ADDR_W-1:0] avs_address_i,
	input  wire logic              avs_read_i,
	input  wire logic              avs_write_i,
	input  wire logic [31:0]       avs_writedata_i,
	input  wire logic [3:0]        avs_byteenable_i,
	output logic [31:0]            avs_readdata_o,
	output logic                   avs_waitrequest_o,
	output logic                   tx_fa_o,
	output logic                   tx_m_o,
	output logic                   tx_s_o,
	output logic                   irq_o
);
	stmf_seq_if seq ();

	stmf_mf_counter u_cnt (
		.clk_i  (clk_i),
		.nrst_i (nrst_i),
		.ce_i   (ce_i),
		.seq    (seq)
	);

	stmf_mf_state_type state_q;
	logic [3:0]        sc_reg_q [SUBCH_NUM];
	logic [3:0]        sh_q     [SUBCH_NUM];
	logic [3:0]        acc_q    [SUBCH_NUM];
	logic [3:0]        q_acc_q;
	logic [3:0]        rx_nib_q;
	logic              sel_every_q;
	logic              init_q;
	logic              det_q;
	logic [2:1]        stat_q;
	logic [2:1]        en_q;
	logic              cv_seen_q;
	logic              fa_echo_q;
	logic              wait_q;
	logic [31:0]       rdata_q;
	logic              tx_fa_q;
	logic              tx_m_q;
	logic              tx_s_q;
	logic              irq_q;
	logic              post_rst_q;

	logic [4:0] next_idx;
	logic [2:0] sub_n;
	logic [1:0] bitn_n;
	logic [2:0] sub_c;
	logic       nxt_first;
	logic       tx_on;
	logic       wrap;
	logic       rx_valid_mf;
	logic       hit_fa;
	logic       hit_m;
	logic       hit_s;
	logic       wr_go;
	logic       rd_go;
	logic [3:0] new_nib;
	logic       mf_evt;
	logic       fev_evt;
	logic [3:0] tx_nib;
	logic [31:0] rd_mux;

	// frame index for the frame that starts at this tick
	always_comb begin
		if (nt_mode_i && state_q == MF_START) begin
			next_idx = FRAME_FIRST;
		end else if (seq.mf_last) begin
			next_idx = FRAME_FIRST;
		end else begin
			next_idx = seq.frame_idx + 5'h01;
		end
	end

	assign nxt_first = (next_idx == FRAME_FIRST);
	assign sub_n  = 3'(next_idx % 5'd5);
	assign bitn_n = 2'(next_idx / 5'd5);
	assign sub_c  = 3'(seq.frame_idx % 5'd5);
	assign tx_on  = nt_mode_i ? (state_q != MF_OFF) : det_q;
	assign wrap   = frame_tick_i && nxt_first;
	// only a multiframe that ran whole is committed
	assign rx_valid_mf = nt_mode_i ? (state_q == MF_RUN) : det_q;

	assign hit_fa = rx_tick_i && rx_pos_i == FA_BIT_POS;
	assign hit_m  = rx_tick_i && rx_pos_i == M_BIT_POS;
	assign hit_s  = rx_tick_i && rx_pos_i == S_BIT_POS;

	assign seq.frame_tick = frame_tick_i;
	assign seq.align = nt_mode_i ? (frame_tick_i && state_q == MF_START)
		: (hit_m && rx_bit_i);

	// a nibble written mid-multiframe goes out from the next boundary on
	// the shadow loads at the same tick, so frame 1 must read the register itself
	assign tx_nib = nxt_first ? sc_reg_q[sub_n] : sh_q[sub_n];

	// nt multiframe control
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			state_q <= MF_OFF;
		end else if (ce_i) begin
			case (state_q)
				MF_OFF: begin
					if (nt_mode_i && init_q) begin
						state_q <= MF_START;
					end
				end
				MF_START: begin
					if (!init_q) begin
						state_q <= MF_OFF;
					end else if (frame_tick_i) begin
						state_q <= MF_RUN;
					end
				end
				MF_RUN: begin
					if (!init_q || !nt_mode_i) begin
						state_q <= MF_OFF;
					end
				end
				default: begin
					state_q <= MF_OFF;
				end
			endcase
		end
	end

	// te detection: M seen sets it, frame 1 without M drops it
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			det_q <= 1'b0;
		end else if (ce_i && !nt_mode_i && hit_m) begin
			if (rx_bit_i) begin
				det_q <= 1'b1;
			end else if (seq.frame_idx == FRAME_FIRST) begin
				det_q <= 1'b0;
			end
		end
	end

	// transmit bits, held for the whole frame
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			tx_fa_q <= 1'b0;
			tx_m_q  <= 1'b0;
			tx_s_q  <= 1'b0;
		end else if (ce_i && frame_tick_i) begin
			if (nt_mode_i) begin
				tx_fa_q <= tx_on && sub_n == 3'd0;
				tx_m_q  <= tx_on && nxt_first;
				tx_s_q  <= tx_on && tx_nib[~bitn_n];
			end else begin
				if (det_q) begin
					tx_fa_q <= (sub_n == 3'd0) && tx_nib[~bitn_n];
				end else begin
					tx_fa_q <= fa_echo_q;
				end
				tx_m_q <= 1'b0;
				tx_s_q <= 1'b0;
			end
		end
	end

	// te keeps the last received Fa for wrapping
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			fa_echo_q <= 1'b0;
		end else if (ce_i && hit_fa) begin
			fa_echo_q <= rx_bit_i;
		end
	end

	// nt collects Q from the Fa slots of frames 1, 6, 11, 16
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			q_acc_q <= NIB_ONES;
		end else if (ce_i && nt_mode_i && hit_fa && sub_c == 3'd0) begin
			q_acc_q <= {q_acc_q[2:0], rx_bit_i};
		end
	end

	assign wr_go = avs_write_i && !wait_q && avs_byteenable_i[0];
	assign rd_go = avs_read_i && wait_q;

	genvar gi;
	generate
		for (gi = 0; gi < SUBCH_NUM; gi = gi + 1) begin : g_sc
			localparam logic [2:0] SC = 3'(gi);
			// te shifts S bits of its own subchannel, msb first
			always_ff @(posedge clk_i) begin
				if (!nrst_i) begin
					acc_q[gi] <= NIB_ZERO;
				end else if (ce_i && !nt_mode_i && det_q && hit_s && sub_c == SC) begin
					acc_q[gi] <= {acc_q[gi][2:0], rx_bit_i};
				end
			end
			always_ff @(posedge clk_i) begin
				if (!nrst_i) begin
					sh_q[gi] <= (gi == 0 && !nt_mode_i) ? NIB_ONES : NIB_ZERO;
				end else if (ce_i && wrap) begin
					sh_q[gi] <= sc_reg_q[gi];
				end
			end
		end
	endgenerate

	// sc_reg_q[0] is the SC1 nibble in nt, the Q nibble in te
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			sc_reg_q[0] <= nt_mode_i ? NIB_ZERO : NIB_ONES;
		end else if (ce_i && wr_go && avs_address_i == OFS_S_TX_SC1) begin
			sc_reg_q[0] <= avs_writedata_i[7:4];
		end
	end

	// te overwrites SC2..SC5 at the boundary; bus writes only count in nt
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			sc_reg_q[1] <= NIB_ZERO;
			sc_reg_q[2] <= NIB_ZERO;
			sc_reg_q[3] <= NIB_ZERO;
			sc_reg_q[4] <= NIB_ZERO;
		end else if (ce_i) begin
			if (!nt_mode_i) begin
				if (wrap && rx_valid_mf) begin
					sc_reg_q[1] <= acc_q[1];
					sc_reg_q[2] <= acc_q[2];
					sc_reg_q[3] <= acc_q[3];
					sc_reg_q[4] <= acc_q[4];
				end
			end else if (wr_go && avs_address_i == OFS_S_SC23) begin
				sc_reg_q[1] <= avs_writedata_i[7:4];
				sc_reg_q[2] <= avs_writedata_i[3:0];
			end else if (wr_go && avs_address_i == OFS_S_SC45) begin
				sc_reg_q[3] <= avs_writedata_i[7:4];
				sc_reg_q[4] <= avs_writedata_i[3:0];
			end
		end
	end

	// received nibble: Q in nt, SC1 in te
	assign new_nib = nt_mode_i ? q_acc_q : acc_q[0];

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			rx_nib_q <= nt_mode_i ? NIB_ONES : NIB_ZERO;
		end else if (ce_i && wrap && rx_valid_mf) begin
			rx_nib_q <= new_nib;
		end
	end

	assign mf_evt = wrap && rx_valid_mf
		&& (sel_every_q || new_nib != rx_nib_q);

	// violations are latched in one flag per multiframe and reported at its end
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			cv_seen_q <= 1'b0;
		end else if (ce_i) begin
			if (wrap) begin
				cv_seen_q <= 1'b0;
			end else if (nt_mode_i && rx_cv_i) begin
				cv_seen_q <= 1'b1;
			end
		end
	end

	assign fev_evt = wrap && nt_mode_i && state_q == MF_RUN
		&& (cv_seen_q || rx_cv_i);

	// sticky status, cleared by writing 0; a new event beats the clear
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			stat_q <= 2'b00;
		end else if (ce_i) begin
			if (fev_evt) begin
				stat_q[IRQ_FEV_BIT] <= 1'b1;
			end else if (wr_go && avs_address_i == OFS_IRQ_STAT
				&& !avs_writedata_i[IRQ_FEV_BIT]) begin
				stat_q[IRQ_FEV_BIT] <= 1'b0;
			end
			if (mf_evt) begin
				stat_q[IRQ_MF_BIT] <= 1'b1;
			end else if (wr_go && avs_address_i == OFS_IRQ_STAT
				&& !avs_writedata_i[IRQ_MF_BIT]) begin
				stat_q[IRQ_MF_BIT] <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			en_q        <= 2'b00;
			sel_every_q <= 1'b0;
			init_q      <= 1'b0;
		end else if (ce_i && wr_go) begin
			case (avs_address_i)
				OFS_IRQ_EN:  en_q        <= avs_writedata_i[2:1];
				OFS_MF_STAT: sel_every_q <= avs_writedata_i[SEL_EVERY_BIT];
				OFS_CTRL:    init_q      <= avs_writedata_i[CTL_INIT_BIT];
				default:     en_q        <= en_q;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			irq_q <= 1'b0;
		end else if (ce_i) begin
			irq_q <= |(stat_q & en_q);
		end
	end

	always_comb begin
		rd_mux = 32'h0000_0000;
		case (avs_address_i)
			OFS_S_TX_SC1: rd_mux[7:4] = sc_reg_q[0];
			OFS_S_SC23:   rd_mux[7:0] = {sc_reg_q[1], sc_reg_q[2]};
			OFS_S_SC45:   rd_mux[7:0] = {sc_reg_q[3], sc_reg_q[4]};
			OFS_MF_STAT:  rd_mux[7:0] = {rx_nib_q, 1'b0, sel_every_q, 2'b00};
			OFS_IRQ_STAT: rd_mux[2:1] = stat_q;
			OFS_IRQ_EN:   rd_mux[2:1] = en_q;
			OFS_CTRL: begin
				rd_mux[CTL_INIT_BIT] = init_q;
				rd_mux[CTL_DET_BIT]  = nt_mode_i ? (state_q == MF_RUN) : det_q;
			end
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	// fixed one wait cycle; avoids a combinational path from the bus request
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			wait_q  <= 1'b1;
			rdata_q <= 32'h0000_0000;
		end else if (ce_i) begin
			wait_q <= !((avs_read_i || avs_write_i) && wait_q);
			if (rd_go) begin
				rdata_q <= rd_mux;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		post_rst_q <= !nrst_i;
	end

	assign avs_readdata_o    = rdata_q;
	assign avs_waitrequest_o = wait_q;
	assign tx_fa_o           = tx_fa_q;
	assign tx_m_o            = tx_m_q;
	assign tx_s_o            = tx_s_q;
	assign irq_o             = irq_q;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!nrst_i);

	irq_gate_a: assert property (
		ce_i && !(|(stat_q & en_q)) |=> !irq_o)
		else $error("irq raised without an enabled status bit");
	fa_idle_a: assert property (
		ce_i && frame_tick_i && nt_mode_i && state_q == MF_OFF |=> !tx_fa_o && !tx_m_o)
		else $error("nt sent Fa or M while multiframing off");
	rst_vals_a: assert property (
		post_rst_q |-> sc_reg_q[0] == (nt_mode_i ? NIB_ZERO : NIB_ONES) && sc_reg_q[3] == NIB_ZERO)
		else $error("subchannel nibble wrong after reset");
	init_m_a: assert property (
		ce_i && frame_tick_i && nt_mode_i && state_q == MF_START && init_q
		|=> tx_m_o && tx_fa_o && state_q == MF_RUN)
		else $error("initiate did not send M in next frame");
	m_frame_a: assert property (
		ce_i && frame_tick_i && nt_mode_i && state_q == MF_RUN |=> tx_m_o == $past(nxt_first))
		else $error("M not limited to frame 1");
	q_commit_a: assert property (
		ce_i && wrap && nt_mode_i && state_q == MF_RUN |=> rx_nib_q == $past(q_acc_q))
		else $error("Q nibble not committed at boundary");
	mf_every_a: assert property (
		ce_i && wrap && rx_valid_mf && sel_every_q |=> stat_q[IRQ_MF_BIT] ##1 (irq_o || !en_q[IRQ_MF_BIT] || !ce_i))
		else $error("every-multiframe event missed");
	fev_set_a: assert property (
		ce_i && fev_evt |=> stat_q[IRQ_FEV_BIT])
		else $error("far-end violation not flagged");
	te_align_a: assert property (
		ce_i && !nt_mode_i && hit_m && rx_bit_i |=> seq.frame_idx == FRAME_FIRST && det_q)
		else $error("te did not align to received M");
	bus_wait_a: assert property (
		ce_i && (avs_read_i || avs_write_i) && wait_q |=> !avs_waitrequest_o)
		else $error("waitrequest not released after one cycle");

	nt_run_c: cover property (ce_i && nt_mode_i && state_q == MF_START ##[1:40] state_q == MF_RUN);
	te_det_c: cover property (ce_i && !nt_mode_i && $rose(det_q));
	fev_c:    cover property (fev_evt && ce_i);
	newnib_c: cover property (mf_evt && !sel_every_q && ce_i);
endmodule
`default_nettype wire

// ==== verilog/stmf_mf_counter.sv ====
`timescale 1ns/10ps
`default_nettype none
module stmf_mf_counter
	import stmf_pkg::*;
(
	input  wire logic clk_i,
	input  wire logic nrst_i,
	input  wire logic ce_i,
	stmf_seq_if.cnt   seq
);
	logic [4:0] idx_q;

	// align wins over the frame advance: it marks the current frame as frame 1
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			idx_q <= FRAME_FIRST;
		end else if (ce_i) begin
			if (seq.align) begin
				idx_q <= FRAME_FIRST;
			end else if (seq.frame_tick) begin
				idx_q <= (idx_q == FRAME_LAST) ? FRAME_FIRST : idx_q + 5'h01;
			end
		end
	end

	assign seq.frame_idx = idx_q;
	assign seq.mf_last   = (idx_q == FRAME_LAST);
endmodule
`default_nettype wire

// ==== verilog/stmf_pkg.sv ====
package stmf_pkg;
	localparam int FRAMES_PER_MF = 20;
	localparam int SUBCH_NUM     = 5;
	localparam int NIB_W         = 4;
	localparam int ADDR_W        = 5;
	localparam int MF_TIME_US    = 5000;

	localparam logic [5:0] FA_BIT_POS = 6'h0e;
	localparam logic [5:0] M_BIT_POS  = 6'h1a;
	localparam logic [5:0] S_BIT_POS  = 6'h25;

	localparam logic [ADDR_W-1:0] OFS_S_TX_SC1 = 5'h00;
	localparam logic [ADDR_W-1:0] OFS_S_SC23   = 5'h04;
	localparam logic [ADDR_W-1:0] OFS_S_SC45   = 5'h08;
	localparam logic [ADDR_W-1:0] OFS_MF_STAT  = 5'h0c;
	localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 5'h10;
	localparam logic [ADDR_W-1:0] OFS_IRQ_EN   = 5'h14;
	localparam logic [ADDR_W-1:0] OFS_CTRL     = 5'h18;

	localparam int SEL_EVERY_BIT = 2;
	localparam int IRQ_FEV_BIT   = 1;
	localparam int IRQ_MF_BIT    = 2;
	localparam int CTL_INIT_BIT  = 5;
	localparam int CTL_DET_BIT   = 1;

	localparam logic [3:0] NIB_ZERO = 4'h0;
	localparam logic [3:0] NIB_ONES = 4'hf;
	localparam logic [4:0] FRAME_FIRST = 5'h00;
	localparam logic [4:0] FRAME_LAST  = 5'h13;

	typedef enum logic [1:0] {
		MF_OFF   = 2'b00,
		MF_START = 2'b01,
		MF_RUN   = 2'b11
	} stmf_mf_state_type;
endpackage

// ==== verilog/stmf_seq_if.sv ====
`timescale 1ns/10ps
`default_nettype none
interface stmf_seq_if;
	logic       frame_tick;
	logic       align;
	logic [4:0] frame_idx;
	logic       mf_last;
	modport ctl (output frame_tick, output align, input frame_idx, input mf_last);
	modport cnt (input frame_tick, input align, output frame_idx, output mf_last);
endinterface
`default_nettype wire
